// >>> rtl/refsel_pkg.sv
// package: constants and structs for the pll reference select and switchover block
package refsel_pkg;
   // bit positions inside the 8-bit reference configuration byte
   localparam int REFCFG_DIFF_EN_BIT = 0;
   localparam int REFCFG_PRI_EN_BIT = 1;
   localparam int REFCFG_SEC_EN_BIT = 2;
   localparam int REFCFG_NONREVERT_BIT = 3;
   localparam int REFCFG_AUTO_BIT = 4;
   localparam int REFCFG_USE_PIN_BIT = 5;
   localparam int REFCFG_SEL_SEC_BIT = 6;
   localparam int REFCFG_DEGLITCH_OFF_BIT = 7;
   localparam logic [7:0] REFCFG_RESET = 8'h00;
   localparam logic [2:0] CPMODE_RESET = 3'h0;
   localparam logic [2:0] CPCUR_RESET = 3'h0;
   localparam logic [1:0] ABP_RESET = 2'h0;
   localparam logic [1:0] MISS_FALLS = 2'h2;
   localparam logic [2:0] RETURN_RISES = 3'h4;

   typedef enum logic [1:0] {
      CP_HIZ,
      CP_NORMAL,
      CP_FORCE_UP,
      CP_FORCE_DOWN
   } cp_behaviour_t;

   typedef struct packed {
      logic diff_pd;
      logic pri_pd;
      logic sec_pd;
      logic xtal_amp_on;
      logic dc_offset_on;
      logic doubler_on;
   } input_ctrl_t;

   typedef struct packed {
      logic up;
      logic down;
      logic hiz;
      logic [2:0] current;
      logic [1:0] abp_width;
   } cp_ctrl_t;

   function automatic cp_behaviour_t cp_decode(input logic [2:0] mode);
      cp_behaviour_t res;
      res = CP_HIZ;
      unique case (mode)
         3'h0, 3'h4: res = CP_HIZ;
         3'h1, 3'h5: res = CP_FORCE_UP;
         3'h2, 3'h6: res = CP_FORCE_DOWN;
         default: res = CP_NORMAL;
      endcase
      return res;
   endfunction : cp_decode
endpackage : refsel_pkg

// >>> rtl/edge_sync.sv
// module: two-stage synchroniser with rise and fall detection
`timescale 1ns/1ns
module edge_sync (
   input wire logic clk, // sampling clock
   input wire logic rst, // async reset, active high
   input wire logic async_in, // level from outside the domain
   output logic level, // synchronised level
   output logic rise, // one-cycle pulse on rising edge
   output logic fall // one-cycle pulse on falling edge
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign level = sync_reg;
   assign rise = sync_reg & ~last_reg;
   assign fall = ~sync_reg & last_reg;
endmodule : edge_sync

// >>> rtl/pll_refsel.sv
// module: pll front-end control, reference selection and switchover
`timescale 1ns/1ns
// Function
// - two-bit field picks antibacklash pulse width
// - normal mode pumps up lagging, down leading
// - mode field: hiz, normal, force up, down
// - eight current steps, top step 4.8 mA
// - all reference inputs off after reset
// - input type chosen by reference config byte
// - offset bit lowers single-ended bias 140 mV
// - differential receiver off unless selected, pll up
// - single-ended buffers off: pll down, own, diff
// - crystal enable turns on maintaining amplifier
// - doubler presents twice reference frequency
// - switching only in dual single-ended mode
// - manual select from config bit or pin
// - primary missing after two secondary falls
// - secondary used from next secondary rise
// - revertive returns after four clean primary rises
// - nonrevertive stays; manual mode returns primary
// - deglitch blocks misaligned edges while switching
module pll_refsel (
   input wire logic MCLK, // 125 MHz system clock
   input wire logic RST, // async reset, active high
   input wire logic PLL_PD, // pll powered down
   input wire logic [7:0] REF_CFG, // reference configuration byte
   input wire logic DC_OFFSET, // single-ended dc offset enable
   input wire logic XTAL_EN, // crystal_amplifier_enable
   input wire logic DOUBLER_EN, // reference doubler enable
   input wire logic [2:0] CP_MODE, // charge_pump mode field
   input wire logic [2:0] CP_CURRENT, // charge_pump current step
   input wire logic [1:0] ABP_WIDTH, // antibacklash width select
   input wire logic REF_SEL_PIN, // external select pin, high = secondary
   input wire logic PRIMARY_REFERENCE, // primary reference clock pin
   input wire logic SECONDARY_REFERENCE, // secondary reference clock pin
   input wire logic FB_LAGS, // detector: feedback lags reference
   input wire logic FB_LEADS, // detector: feedback leads reference
   output refsel_pkg::input_ctrl_t IN_CTRL, // input buffer controls
   output refsel_pkg::cp_ctrl_t CP_CTRL, // charge_pump commands
   output logic REF_TO_PLL, // selected, deglitched reference
   output logic SEC_ACTIVE, // secondary in use
   output logic PRI_MISSING, // primary declared missing
   output logic SWITCH_BUSY // deglitch hold in progress
);
   logic pri_lvl, pri_rise, pri_fall, sec_lvl, sec_rise, sec_fall;
   logic pin_lvl;

   edge_sync u_pri (
      .clk(MCLK),
      .rst(RST),
      .async_in(PRIMARY_REFERENCE),
      .level(pri_lvl),
      .rise(pri_rise),
      .fall(pri_fall)
   );

   edge_sync u_sec (
      .clk(MCLK),
      .rst(RST),
      .async_in(SECONDARY_REFERENCE),
      .level(sec_lvl),
      .rise(sec_rise),
      .fall(sec_fall)
   );

   // select pin is asynchronous too; a raw read could split the select logic
   edge_sync u_pin (
      .clk(MCLK),
      .rst(RST),
      .async_in(REF_SEL_PIN),
      .level(pin_lvl),
      .rise(),
      .fall()
   );

   // configuration decode
   wire diff_sel = REF_CFG[refsel_pkg::REFCFG_DIFF_EN_BIT];
   wire pri_en = REF_CFG[refsel_pkg::REFCFG_PRI_EN_BIT];
   wire sec_en = REF_CFG[refsel_pkg::REFCFG_SEC_EN_BIT];
   wire nonrevert = REF_CFG[refsel_pkg::REFCFG_NONREVERT_BIT];
   wire deglitch_off = REF_CFG[refsel_pkg::REFCFG_DEGLITCH_OFF_BIT];
   wire dual_mode = pri_en & sec_en & ~diff_sel & ~PLL_PD;
   wire auto_mode = dual_mode & REF_CFG[refsel_pkg::REFCFG_AUTO_BIT];
   wire manual_want_sec = REF_CFG[refsel_pkg::REFCFG_USE_PIN_BIT] ?
                          pin_lvl : REF_CFG[refsel_pkg::REFCFG_SEL_SEC_BIT];
   wire pri_edge = pri_rise | pri_fall;

   // buffer power control; REF_CFG resets to zero so every input is off
   assign IN_CTRL.diff_pd = ~diff_sel | PLL_PD;
   assign IN_CTRL.pri_pd = PLL_PD | ~pri_en | diff_sel;
   assign IN_CTRL.sec_pd = PLL_PD | ~sec_en | diff_sel;
   assign IN_CTRL.xtal_amp_on = XTAL_EN & ~PLL_PD;
   assign IN_CTRL.dc_offset_on = DC_OFFSET & ~diff_sel;
   assign IN_CTRL.doubler_on = DOUBLER_EN & ~PLL_PD;

   // missing-reference monitor
   logic [1:0] miss_cnt_reg, miss_cnt_next;
   logic [2:0] ret_cnt_reg, ret_cnt_next;
   logic missing_reg, missing_next;
   logic [1:0] gap_cnt_reg, gap_cnt_next;

   always_comb
   begin
      miss_cnt_next = miss_cnt_reg;
      if (!auto_mode || pri_edge)
         miss_cnt_next = 2'h0;
      else if (sec_fall && miss_cnt_reg != refsel_pkg::MISS_FALLS)
         miss_cnt_next = miss_cnt_reg + 2'h1;
   end

   // falls of secondary since the last primary rise, for the return check
   always_comb
   begin
      gap_cnt_next = gap_cnt_reg;
      if (pri_rise)
         gap_cnt_next = 2'h0;
      else if (sec_fall && gap_cnt_reg != refsel_pkg::MISS_FALLS)
         gap_cnt_next = gap_cnt_reg + 2'h1;
   end

   always_comb
   begin
      ret_cnt_next = ret_cnt_reg;
      if (!missing_reg)
         ret_cnt_next = 3'h0;
      else if (pri_rise)
      begin
         if (gap_cnt_reg == refsel_pkg::MISS_FALLS)
            ret_cnt_next = 3'h1;
         else if (ret_cnt_reg != refsel_pkg::RETURN_RISES)
            ret_cnt_next = ret_cnt_reg + 3'h1;
      end
   end

   wire miss_hit = (miss_cnt_next == refsel_pkg::MISS_FALLS);
   wire pri_back = (ret_cnt_next == refsel_pkg::RETURN_RISES);

   always_comb
   begin
      missing_next = missing_reg;
      if (!auto_mode)
         missing_next = 1'b0;
      else if (miss_hit)
         missing_next = 1'b1;
      else if (pri_back)
         missing_next = 1'b0;
   end

   // auto selection state; nonrevertive latches the secondary
   logic auto_sec_reg, auto_sec_next;

   always_comb
   begin
      auto_sec_next = auto_sec_reg;
      if (!auto_mode)
         auto_sec_next = 1'b0;
      else if (missing_reg && sec_rise)
         auto_sec_next = 1'b1;
      else if (auto_sec_reg && !missing_reg && !nonrevert)
         auto_sec_next = 1'b0;
   end // with nonrevert, only leaving auto mode returns to primary

   wire want_sec = auto_mode ? auto_sec_reg : (dual_mode & manual_want_sec);

   // deglitch: on a change, output goes low and stays low until the new
   // reference rises; avoids runt or misaligned edges into the pll
   typedef enum logic [1:0] {
      S_RUN,
      S_WAIT_LOW,
      S_WAIT_RISE
   } sw_state_t;
   sw_state_t state_reg, state_next;
   logic cur_sec_reg, cur_sec_next;
   logic out_reg, out_next;

   wire cur_lvl = cur_sec_reg ? sec_lvl : pri_lvl;
   wire tgt_lvl = want_sec ? sec_lvl : pri_lvl;
   wire tgt_rise = want_sec ? sec_rise : pri_rise;
   wire changing = (want_sec != cur_sec_reg);

   always_comb
   begin
      state_next = state_reg;
      cur_sec_next = cur_sec_reg;
      out_next = cur_lvl;
      unique case (state_reg)
         S_RUN:
         begin
            if (changing && deglitch_off)
            begin
               cur_sec_next = want_sec;
               out_next = tgt_lvl;
            end
            else if (changing)
            begin
               state_next = S_WAIT_LOW;
               out_next = 1'b0;
            end
         end
         S_WAIT_LOW:
         begin
            out_next = 1'b0;
            if (!tgt_lvl)
               state_next = S_WAIT_RISE;
         end
         S_WAIT_RISE:
         begin
            out_next = 1'b0;
            if (tgt_rise)
            begin
               state_next = S_RUN;
               cur_sec_next = want_sec;
               out_next = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         miss_cnt_reg <= 2'h0;
         gap_cnt_reg <= 2'h0;
         ret_cnt_reg <= 3'h0;
         missing_reg <= 1'b0;
         auto_sec_reg <= 1'b0;
         state_reg <= S_RUN;
         cur_sec_reg <= 1'b0;
         out_reg <= 1'b0;
      end
      else
      begin
         miss_cnt_reg <= miss_cnt_next;
         gap_cnt_reg <= gap_cnt_next;
         ret_cnt_reg <= ret_cnt_next;
         missing_reg <= missing_next;
         auto_sec_reg <= auto_sec_next;
         state_reg <= state_next;
         cur_sec_reg <= cur_sec_next;
         out_reg <= out_next;
      end
   end

   assign REF_TO_PLL = out_reg;
   assign SEC_ACTIVE = cur_sec_reg;
   assign PRI_MISSING = missing_reg;
   assign SWITCH_BUSY = (state_reg != S_RUN);

   // charge pump command path
   refsel_pkg::cp_behaviour_t cp_beh;
   assign cp_beh = refsel_pkg::cp_decode(CP_MODE);
   wire cp_up_next = (cp_beh == refsel_pkg::CP_FORCE_UP) |
                     ((cp_beh == refsel_pkg::CP_NORMAL) & FB_LAGS & ~FB_LEADS);
   wire cp_dn_next = (cp_beh == refsel_pkg::CP_FORCE_DOWN) |
                     ((cp_beh == refsel_pkg::CP_NORMAL) & FB_LEADS & ~FB_LAGS);
   logic cp_up_reg, cp_dn_reg, cp_hiz_reg;
   logic [2:0] cp_cur_reg;
   logic [1:0] abp_reg;

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         cp_up_reg <= 1'b0;
         cp_dn_reg <= 1'b0;
         cp_hiz_reg <= 1'b1;
         cp_cur_reg <= refsel_pkg::CPCUR_RESET;
         abp_reg <= refsel_pkg::ABP_RESET;
      end
      else
      begin
         cp_up_reg <= cp_up_next & ~PLL_PD;
         cp_dn_reg <= cp_dn_next & ~PLL_PD;
         cp_hiz_reg <= (cp_beh == refsel_pkg::CP_HIZ) | PLL_PD;
         cp_cur_reg <= CP_CURRENT;
         abp_reg <= ABP_WIDTH;
      end
   end

   assign CP_CTRL.up = cp_up_reg;
   assign CP_CTRL.down = cp_dn_reg;
   assign CP_CTRL.hiz = cp_hiz_reg;
   assign CP_CTRL.current = cp_cur_reg;
   assign CP_CTRL.abp_width = abp_reg;

   // assertions
   buf_reset_off_a: assert property (@(posedge MCLK) disable iff (RST)
      (REF_CFG == refsel_pkg::REFCFG_RESET) |-> (IN_CTRL.pri_pd & IN_CTRL.sec_pd & IN_CTRL.diff_pd))
      else $error("reference input powered with config cleared");
   diff_pd_rule_a: assert property (@(posedge MCLK) disable iff (RST)
      (PLL_PD || !diff_sel) |-> IN_CTRL.diff_pd)
      else $error("differential receiver on while not selected");
   se_pd_rule_a: assert property (@(posedge MCLK) disable iff (RST)
      (diff_sel || PLL_PD) |-> (IN_CTRL.pri_pd && IN_CTRL.sec_pd))
      else $error("single-ended buffer on in diff mode or pll down");
   cp_hiz_mode_a: assert property (@(posedge MCLK) disable iff (RST)
      (cp_beh == refsel_pkg::CP_HIZ) |=> (CP_CTRL.hiz && !CP_CTRL.up && !CP_CTRL.down))
      else $error("charge pump not high impedance in holdover");
   cp_normal_up_a: assert property (@(posedge MCLK) disable iff (RST)
      (cp_beh == refsel_pkg::CP_NORMAL && FB_LAGS && !FB_LEADS && !PLL_PD) |=> CP_CTRL.up)
      else $error("no pump up on lagging feedback");
   abp_follow_a: assert property (@(posedge MCLK) disable iff (RST)
      ##1 (CP_CTRL.abp_width == $past(ABP_WIDTH)))
      else $error("antibacklash width not taken");
   miss_declare_a: assert property (@(posedge MCLK) disable iff (RST)
      (auto_mode && !missing_reg && miss_hit) |=> PRI_MISSING)
      else $error("primary not declared missing after two falls");
   no_switch_single_a: assert property (@(posedge MCLK) disable iff (RST)
      (!dual_mode && state_reg == S_RUN && !cur_sec_reg) |=> !SEC_ACTIVE)
      else $error("switched outside dual single-ended mode");
   sec_on_rise_a: assert property (@(posedge MCLK) disable iff (RST)
      $rose(auto_sec_reg) |-> $past(sec_rise))
      else $error("secondary chosen away from a secondary rise");
   deglitch_low_a: assert property (@(posedge MCLK) disable iff (RST)
      (state_reg == S_WAIT_RISE && !tgt_rise) |=> !REF_TO_PLL)
      else $error("edge passed during deglitch hold");
   manual_ignore_a: assert property (@(posedge MCLK) disable iff (RST)
      (auto_mode && !auto_sec_reg) |-> !want_sec)
      else $error("manual select honoured in auto mode");
   cp_force_up_a: assert property (@(posedge MCLK) disable iff (RST)
      (cp_beh == refsel_pkg::CP_FORCE_UP && !PLL_PD) |=> (CP_CTRL.up && !CP_CTRL.down && !CP_CTRL.hiz))
      else $error("charge pump not forced up in test mode");
   cp_current_a: assert property (@(posedge MCLK) disable iff (RST)
      ##1 (CP_CTRL.current == $past(CP_CURRENT)))
      else $error("charge pump current step not taken");
   revert_clear_a: assert property (@(posedge MCLK) disable iff (RST)
      (auto_mode && missing_reg && pri_back && !miss_hit) |=> !PRI_MISSING)
      else $error("primary not restored after four clean rises");
   nonrevert_hold_a: assert property (@(posedge MCLK) disable iff (RST)
      (auto_mode && nonrevert && auto_sec_reg) |=> auto_sec_reg)
      else $error("left secondary while nonrevertive");
   xtal_amp_a: assert property (@(posedge MCLK) disable iff (RST)
      (XTAL_EN && !PLL_PD) |-> IN_CTRL.xtal_amp_on)
      else $error("crystal amplifier off while enabled");

   switch_sec_c: cover property (@(posedge MCLK) disable iff (RST) $rose(SEC_ACTIVE));
   revert_c: cover property (@(posedge MCLK) disable iff (RST) $fell(PRI_MISSING) && auto_mode);
   deglitch_c: cover property (@(posedge MCLK) disable iff (RST) $fell(SWITCH_BUSY));
   nonrevert_stay_c: cover property (@(posedge MCLK) disable iff (RST)
      auto_mode && nonrevert && SEC_ACTIVE && !PRI_MISSING);
   bypass_c: cover property (@(posedge MCLK) disable iff (RST) $rose(SEC_ACTIVE) && deglitch_off);
endmodule : pll_refsel

// >>> test/ref_source_model.sv
// model: two reference clock sources and the manual select pin
`timescale 1ns/1ns
module ref_source_model (
   input wire logic pri_run, // primary toggles while high
   input wire logic sec_run, // secondary toggles while high
   input wire logic sel_in, // wanted select level
   output logic pri_clk, // primary_reference
   output logic sec_clk, // secondary_reference
   output logic sel_pin // select pin, high = secondary
);
   assign sel_pin = sel_in;
   // a stopped source parks low, like an idle cmos driver
   initial
   begin
      pri_clk = 1'b0;
      #3;
      forever
      begin
         #62 pri_clk = pri_run & ~pri_clk;
         #63 pri_clk = pri_run & ~pri_clk;
      end
   end
   initial
   begin
      sec_clk = 1'b0;
      #41;
      forever
      begin
         #62 sec_clk = sec_run & ~sec_clk;
         #63 sec_clk = sec_run & ~sec_clk;
      end
   end
endmodule : ref_source_model

// >>> test/tb_pll_refsel.sv
// testbench: reference control, charge pump and switchover of pll_refsel
`timescale 1ns/1ns
module tb_pll_refsel;
   logic mclk;
   logic rst = 1'b1;
   logic pll_pd = 1'b0;
   logic dc_offset = 1'b0;
   logic xtal_en = 1'b0;
   logic doubler_en = 1'b0;
   logic fb_lags = 1'b0;
   logic fb_leads = 1'b0;
   logic [7:0] ref_cfg = 8'h00;
   logic [2:0] cp_mode = 3'h0;
   logic [2:0] cp_current = 3'h0;
   logic [1:0] abp_width = 2'h0;
   logic pri_run = 1'b1;
   logic sec_run = 1'b1;
   logic sel_in = 1'b0;
   logic pri_clk, sec_clk, sel_pin, ref_to_pll, sec_active, pri_missing, switch_busy;
   refsel_pkg::input_ctrl_t in_ctrl;
   refsel_pkg::cp_ctrl_t cp_ctrl;
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   int seed = 25;
   int highs;
   logic busy_seen = 1'b0;

   pll_refsel dut (.MCLK(mclk), .RST(rst), .PLL_PD(pll_pd), .REF_CFG(ref_cfg), .DC_OFFSET(dc_offset),
      .XTAL_EN(xtal_en), .DOUBLER_EN(doubler_en), .CP_MODE(cp_mode), .CP_CURRENT(cp_current),
      .ABP_WIDTH(abp_width), .REF_SEL_PIN(sel_pin), .PRIMARY_REFERENCE(pri_clk),
      .SECONDARY_REFERENCE(sec_clk), .FB_LAGS(fb_lags), .FB_LEADS(fb_leads), .IN_CTRL(in_ctrl),
      .CP_CTRL(cp_ctrl), .REF_TO_PLL(ref_to_pll), .SEC_ACTIVE(sec_active), .PRI_MISSING(pri_missing),
      .SWITCH_BUSY(switch_busy));

   ref_source_model src (.pri_run(pri_run), .sec_run(sec_run), .sel_in(sel_in), .pri_clk(pri_clk),
      .sec_clk(sec_clk), .sel_pin(sel_pin));

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic stop_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   // switchover tests need a few thousand cycles at most
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         failures++;
         stop_test();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   function automatic refsel_pkg::input_ctrl_t exp_in(input logic [7:0] c, input logic pd, input logic dc,
      input logic xt, input logic db);
      refsel_pkg::input_ctrl_t r;
      r.diff_pd = pd | ~c[refsel_pkg::REFCFG_DIFF_EN_BIT];
      r.pri_pd = pd | ~c[refsel_pkg::REFCFG_PRI_EN_BIT] | c[refsel_pkg::REFCFG_DIFF_EN_BIT];
      r.sec_pd = pd | ~c[refsel_pkg::REFCFG_SEC_EN_BIT] | c[refsel_pkg::REFCFG_DIFF_EN_BIT];
      r.xtal_amp_on = xt & ~pd;
      r.dc_offset_on = dc & ~c[refsel_pkg::REFCFG_DIFF_EN_BIT];
      r.doubler_on = db & ~pd;
      return r;
   endfunction : exp_in

   function automatic refsel_pkg::cp_ctrl_t exp_cp(input logic [2:0] m, input logic [2:0] cur,
      input logic [1:0] w, input logic lag, input logic lead, input logic pd);
      refsel_pkg::cp_ctrl_t r;
      r.current = cur;
      r.abp_width = w;
      r.hiz = pd | (m[1:0] == 2'h0);
      // lag and lead together is no decision: the pump stays idle
      r.up = ~pd & ((m[1:0] == 2'h1) | (m[1:0] == 2'h3 & lag & ~lead));
      r.down = ~pd & ((m[1:0] == 2'h2) | (m[1:0] == 2'h3 & lead & ~lag));
      return r;
   endfunction : exp_cp

   // both single-ended inputs enabled, differential off
   function automatic logic [7:0] mk(input logic aut, input logic nrev, input logic pin, input logic sec,
      input logic dgo);
      logic [7:0] c;
      c = 8'h00;
      c[refsel_pkg::REFCFG_PRI_EN_BIT] = 1'b1;
      c[refsel_pkg::REFCFG_SEC_EN_BIT] = 1'b1;
      c[refsel_pkg::REFCFG_AUTO_BIT] = aut;
      c[refsel_pkg::REFCFG_NONREVERT_BIT] = nrev;
      c[refsel_pkg::REFCFG_USE_PIN_BIT] = pin;
      c[refsel_pkg::REFCFG_SEL_SEC_BIT] = sec;
      c[refsel_pkg::REFCFG_DEGLITCH_OFF_BIT] = dgo;
      return c;
   endfunction : mk

   task automatic wait_for(input logic on_miss, input logic val, input int bound);
      for (int i = 0; i < bound; i++)
      begin
         @(posedge mclk);
         #1;
         if (switch_busy === 1'b1)
         begin
            busy_seen = 1'b1;
            check(8'(ref_to_pll), 8'h00, "held low");
         end
         if ((on_miss ? pri_missing : sec_active) === val) break;
      end
   endtask : wait_for

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : idle

   initial
   begin
      idle(10);
      check(8'({cp_ctrl.hiz, ref_to_pll, sec_active, pri_missing}), 8'h08, "reset outputs");
      check(8'({in_ctrl.diff_pd, in_ctrl.pri_pd, in_ctrl.sec_pd}), 8'h07, "inputs off");
      rst = 1'b0;
      repeat (40)
      begin
         idle(1);
         {pll_pd, dc_offset, xtal_en, doubler_en, ref_cfg} = 12'($random(seed));
         #1;
         check(8'(in_ctrl), 8'(exp_in(ref_cfg, pll_pd, dc_offset, xtal_en, doubler_en)), "inputs");
      end
      repeat (48)
      begin
         idle(1);
         {pll_pd, cp_mode, cp_current, abp_width, fb_lags, fb_leads} = 11'($random(seed));
         idle(1);
         check(8'(cp_ctrl), 8'(exp_cp(cp_mode, cp_current, abp_width, fb_lags, fb_leads, pll_pd)), "pump");
      end
      // loop brought up here; vco band calibration stays with software
      pll_pd = 1'b0;
      ref_cfg = mk(0, 0, 0, 0, 0);
      wait_for(0, 0, 100);
      // differential mode must refuse the manual secondary request
      ref_cfg = mk(0, 0, 0, 1, 0) | (8'h01 << refsel_pkg::REFCFG_DIFF_EN_BIT);
      idle(60);
      check(8'(sec_active), 8'h00, "diff mode switch");
      // register and pin disagree each time, so the wrong source shows
      for (int k = 0; k < 4; k++)
      begin
         sel_in = k[1] ? k[0] : ~k[0];
         ref_cfg = mk(0, 0, k[1], k[1] ? ~k[0] : k[0], 0);
         wait_for(0, k[0], 100);
         check(8'(sec_active), 8'(k[0]), "manual select");
      end
      sel_in = 1'b0;
      ref_cfg = mk(0, 0, 0, 0, 0);
      wait_for(0, 0, 100);
      sec_run = 1'b0;
      idle(40);
      ref_cfg = mk(0, 0, 0, 1, 1);
      wait_for(0, 1, 10);
      check(8'(sec_active), 8'h01, "deglitch off");
      check(8'(switch_busy), 8'h00, "no hold with deglitch off");
      sec_run = 1'b1;
      ref_cfg = mk(0, 0, 0, 0, 0);
      wait_for(0, 0, 100);
      sel_in = 1'b1;
      ref_cfg = mk(1, 0, 1, 1, 0);
      idle(60);
      check(8'({sec_active, pri_missing}), 8'h00, "auto ignores select");
      busy_seen = 1'b0;
      pri_run = 1'b0;
      wait_for(1, 1, 100);
      check(8'(pri_missing), 8'h01, "primary missing");
      wait_for(0, 1, 100);
      check(8'(sec_active), 8'h01, "on secondary");
      check(8'(busy_seen), 8'h01, "switch went through hold");
      highs = 0;
      repeat (64)
      begin
         idle(1);
         if (ref_to_pll === 1'b1) highs++;
      end
      check(8'(highs > 20 && highs < 44), 8'h01, "secondary routed");
      pri_run = 1'b1;
      wait_for(1, 0, 150);
      check(8'(pri_missing), 8'h00, "primary back");
      wait_for(0, 0, 100);
      check(8'(sec_active), 8'h00, "reverted");
      ref_cfg = mk(1, 1, 1, 1, 0);
      pri_run = 1'b0;
      wait_for(0, 1, 200);
      pri_run = 1'b1;
      idle(200);
      check(8'(sec_active), 8'h01, "stays on secondary");
      sel_in = 1'b0;
      ref_cfg = mk(0, 1, 0, 0, 0);
      wait_for(0, 0, 100);
      check(8'(sec_active), 8'h00, "manual return");
      ref_cfg = mk(1, 1, 0, 0, 0);
      idle(60);
      check(8'(sec_active), 8'h00, "auto again");
      stop_test();
   end
endmodule : tb_pll_refsel
